// [core/port_mode_pkg.sv]
`default_nettype none
package port_mode_pkg;

    // Register byte offsets
    localparam logic [4:0] OFF_MODE_CFG = 5'h00;
    localparam logic [4:0] OFF_ADDR = 5'h04;
    localparam logic [4:0] OFF_DATA = 5'h08;
    localparam logic [4:0] OFF_IRQ_STATUS = 5'h0C;
    localparam logic [4:0] OFF_IRQ_CLEAR = 5'h10;
    localparam logic [4:0] OFF_IRQ_ENABLE = 5'h14;
    localparam logic [4:0] OFF_OUT_BUF = 5'h18;
    localparam logic [4:0] OFF_IN_BUF = 5'h1C;

    // Mode configuration field positions
    localparam int BUSY_BIT = 15;
    localparam int IRQ_MODE_SEL_LSB = 13;
    localparam int STEP_LSB = 11;
    localparam int WIDE_BIT = 10;
    localparam int KIND_LSB = 8;
    localparam int DSW_LSB = 6;
    localparam int SW_LSB = 2;
    localparam int HW_LSB = 0;

    // Reset values
    localparam logic [15:0] MODE_CFG_RESET = 16'h0000;
    localparam logic [10:0] ADDR_RESET = 11'h000;
    localparam logic [1:0] IRQ_ENABLE_RESET = 2'h0;

    // Interrupt status bits
    localparam int EVT_PORT = 0;
    localparam int EVT_REFUSED = 1;

    // Port operation kinds
    typedef enum logic [1:0] {
        PORT_LEGACY = 2'b00,
        PORT_ADDRESSED = 2'b01,
        PORT_MASTER_SPLIT = 2'b10,
        PORT_MASTER_COMB = 2'b11
    } port_kind_t;

    // Interrupt request modes
    typedef enum logic [1:0] {
        IRQ_OFF = 2'b00,
        IRQ_EACH = 2'b01,
        IRQ_STALL = 2'b10,
        IRQ_FOURTH = 2'b11
    } irq_mode_t;

    // Address stepping modes
    typedef enum logic [1:0] {
        STEP_HOLD = 2'b00,
        STEP_UP = 2'b01,
        STEP_DOWN = 2'b10,
        STEP_BUFFERED = 2'b11
    } step_mode_t;

    // Master transfer engine states
    typedef enum logic [1:0] {
        ENG_IDLE = 2'b00,
        ENG_SETUP = 2'b01,
        ENG_STROBE = 2'b10,
        ENG_HOLD = 2'b11
    } eng_state_t;

    // Next address for a stepping mode
    function automatic logic [10:0] step_addr(input logic [10:0] a, input logic [1:0] m);
        return (m == STEP_UP) ? a + 11'h001 : (m == STEP_DOWN) ? a - 11'h001 : a;
    endfunction

endpackage
`default_nettype wire

// [core/xfer_if.sv]
`default_nettype none
interface xfer_if;
    logic start;            // One-cycle request for a transfer
    logic is_read;          // Direction of the request
    logic wide;             // Two bytes instead of one
    logic [15:0] wdata;     // Write word
    logic [1:0] setup_code; // Data setup wait code
    logic [3:0] strobe_code;// Extra strobe cycles
    logic [1:0] hold_code;  // Hold wait code
    logic [7:0] din;        // Synchronised pin data
    logic busy;             // Transfer in progress
    logic strobe;           // Strobe phase
    logic addr_phase;       // Setup phase
    logic byte_done;        // Pulse at end of each byte
    logic done;             // Pulse at end of transfer
    logic [7:0] dout;       // Byte on the pins
    logic [15:0] rdata;     // Read word

    modport ctrl (output start, is_read, wide, wdata, setup_code, strobe_code, hold_code, din,
                  input busy, strobe, addr_phase, byte_done, done, dout, rdata);
    modport engine (input start, is_read, wide, wdata, setup_code, strobe_code, hold_code, din,
                    output busy, strobe, addr_phase, byte_done, done, dout, rdata);
endinterface
`default_nettype wire

// [core/xfer_engine.sv]
`default_nettype none
module xfer_engine
    import port_mode_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    xfer_if.engine xf
);

    eng_state_t state_q; // Phase of the byte cycle
    eng_state_t state_d;
    logic [3:0] cnt_q;   // Cycles left in phase
    logic [3:0] cnt_d;
    logic hi_q;          // Second byte in progress
    logic hi_d;
    logic rd_q;          // Latched direction
    logic wide_q;        // Latched width
    logic [15:0] wdat_q; // Latched write word
    logic [15:0] rdat_q; // Assembled read word
    logic [15:0] rdat_d;
    logic last_cyc;      // Final cycle of phase

    assign last_cyc = (cnt_q == 4'h0);
    assign xf.busy = (state_q != ENG_IDLE);
    assign xf.addr_phase = (state_q == ENG_SETUP);
    assign xf.strobe = (state_q == ENG_STROBE);
    assign xf.dout = hi_q ? wdat_q[15:8] : wdat_q[7:0];
    assign xf.byte_done = (state_q == ENG_HOLD) && last_cyc;
    assign xf.done = xf.byte_done && !(wide_q && !hi_q);
    assign xf.rdata = rdat_q;

    // Phase sequencing
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q - 4'h1;
        hi_d = hi_q;
        rdat_d = rdat_q;
        case (state_q)
            ENG_IDLE:
            begin
                cnt_d = {2'b00, xf.setup_code};
                hi_d = 1'b0;
                if (xf.start)
                begin
                    state_d = ENG_SETUP;
                end
            end
            ENG_SETUP:
            begin
                if (last_cyc)
                begin
                    state_d = ENG_STROBE;
                    cnt_d = xf.strobe_code;
                end
            end
            ENG_STROBE:
            begin
                if (last_cyc)
                begin
                    // Capture at strobe end
                    if (rd_q && hi_q)
                    begin
                        rdat_d[15:8] = xf.din;
                    end
                    else if (rd_q)
                    begin
                        rdat_d[7:0] = xf.din;
                    end
                    state_d = ENG_HOLD;
                    cnt_d = {2'b00, xf.hold_code};
                end
            end
            ENG_HOLD:
            begin
                if (last_cyc && wide_q && !hi_q)
                begin
                    // Second byte of a wide word
                    hi_d = 1'b1;
                    state_d = ENG_SETUP;
                    cnt_d = {2'b00, xf.setup_code};
                end
                else if (last_cyc)
                begin
                    state_d = ENG_IDLE;
                end
            end
            default:
            begin
                state_d = ENG_IDLE;
            end
        endcase
    end

    // Engine registers
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_q <= ENG_IDLE;
            cnt_q <= 4'h0;
            hi_q <= 1'b0;
            rd_q <= 1'b0;
            wide_q <= 1'b0;
            wdat_q <= 16'h0000;
            rdat_q <= 16'h0000;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            hi_q <= hi_d;
            rdat_q <= rdat_d;
            if (xf.start && !xf.busy)
            begin
                rd_q <= xf.is_read;
                wide_q <= xf.wide;
                wdat_q <= xf.wdata;
            end
        end
    end

endmodule
`default_nettype wire

// [core/port_mode_control.sv]
// Functional notes
// - Mode 11 buffered: interrupt on fourth buffer
// - Mode 11 addressed: interrupt when address is 11
// - Mode 10: no interrupt, stall during transfer
// - Mode 01: interrupt after every port cycle
// - Stepping 11 legacy: buffer pointers auto advance
// - Stepping 10: address counter counts down
// - Stepping 01 counts up, 00 holds
// - Wide mode: two byte transfers per access
// - Two-bit code selects slave or master kind
// - Setup wait code sets 1 to 4 cycles
//
// Design decisions made here: register access over Avalon-MM and the register addresses.
`default_nettype none
module port_mode_control
    import port_mode_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    input wire logic pin_cs_in,
    input wire logic pin_rd_in,
    input wire logic pin_wr_in,
    input wire logic [1:0] pin_addr_in,
    input wire logic [7:0] pin_data_in,
    output logic [7:0] pin_data_out,
    output logic pin_data_oe_n,
    output logic pin_cs_out,
    output logic pin_rd_out,
    output logic pin_wr_out,
    output logic pin_en_out,
    output logic pin_ctrl_oe_n,
    output logic [10:0] port_addr_lines
);

    xfer_if xf(); // Link to transfer engine

    // Registers
    logic [15:0] cfg_q; // Mode configuration
    logic [10:0] addr_q; // Port address counter
    logic [15:0] mdata_q; // Last master read word
    logic [1:0] status_q, status_d; // Sticky events
    logic [1:0] enable_q; // Event enables
    logic [7:0] out_buf_q [0:3]; // Bytes the host reads
    logic [7:0] in_buf_q [0:3]; // Bytes the host wrote
    logic [1:0] rd_ptr_q; // Host read buffer pointer
    logic [1:0] wr_ptr_q; // Host write buffer pointer
    logic waitreq_q, waitreq_d; // Bus wait flop
    logic [31:0] rd_mux; // Read answer select

    // Pin synchroniser: cs, rd, wr, addr, data
    logic [12:0] s1_q;
    logic [12:0] s2_q;
    logic [12:0] s3_q;
    logic [12:0] stable_q, stable_d; // Value once two stages agree
    logic host_rd_act_q, host_wr_act_q; // Previous host activity

    // Field decode
    port_kind_t kind;
    irq_mode_t irq_mode;
    step_mode_t step_mode;
    logic is_master;
    assign kind = port_kind_t'(cfg_q[KIND_LSB +: 2]);
    assign irq_mode = irq_mode_t'(cfg_q[IRQ_MODE_SEL_LSB +: 2]);
    assign step_mode = step_mode_t'(cfg_q[STEP_LSB +: 2]);
    assign is_master = (kind == PORT_MASTER_SPLIT) || (kind == PORT_MASTER_COMB);

    // Bus decode
    logic req, accept, do_wr, do_rd;
    logic sel_cfg, sel_addr, sel_data, sel_stat, sel_clr, sel_ena, sel_out, sel_in;
    logic hold_off;
    assign req = avs_read || avs_write;
    assign accept = req && !waitreq_q;
    assign do_wr = avs_write && accept;
    assign do_rd = avs_read && accept;
    assign sel_cfg = ({avs_address[4:2], 2'b00} == OFF_MODE_CFG);
    assign sel_addr = ({avs_address[4:2], 2'b00} == OFF_ADDR);
    assign sel_data = ({avs_address[4:2], 2'b00} == OFF_DATA);
    assign sel_stat = ({avs_address[4:2], 2'b00} == OFF_IRQ_STATUS);
    assign sel_clr = ({avs_address[4:2], 2'b00} == OFF_IRQ_CLEAR);
    assign sel_ena = ({avs_address[4:2], 2'b00} == OFF_IRQ_ENABLE);
    assign sel_out = ({avs_address[4:2], 2'b00} == OFF_OUT_BUF);
    assign sel_in = ({avs_address[4:2], 2'b00} == OFF_IN_BUF);
    // Data access waits while a stalled transfer runs
    assign hold_off = (irq_mode == IRQ_STALL) && xf.busy && sel_data && is_master;
    assign waitreq_d = !(req && waitreq_q && !hold_off);

    // Master start and refusal
    logic data_access, refused;
    assign data_access = (do_wr || do_rd) && sel_data && is_master;
    assign refused = data_access && xf.busy;
    assign xf.start = data_access && !xf.busy;
    assign xf.is_read = do_rd;
    assign xf.wide = cfg_q[WIDE_BIT];
    assign xf.wdata = avs_writedata[15:0];
    assign xf.setup_code = cfg_q[DSW_LSB +: 2];
    assign xf.strobe_code = cfg_q[SW_LSB +: 4];
    assign xf.hold_code = cfg_q[HW_LSB +: 2];
    assign xf.din = stable_q[7:0];

    // Host side decode from filtered pins
    logic h_cs, h_rd_act, h_wr_act;
    logic [1:0] h_addr;
    logic rd_end, wr_end;
    logic buffered;
    logic [1:0] rd_idx, wr_idx;
    assign stable_d = (s2_q & s3_q) | (stable_q & (s2_q | s3_q));
    assign h_cs = stable_q[12];
    assign h_rd_act = h_cs && stable_q[11] && !is_master;
    assign h_wr_act = h_cs && stable_q[10] && !is_master;
    assign h_addr = stable_q[9:8];
    assign rd_end = host_rd_act_q && !h_rd_act;
    assign wr_end = host_wr_act_q && !h_wr_act;
    assign buffered = (kind == PORT_LEGACY) && (step_mode == STEP_BUFFERED);
    assign rd_idx = (kind == PORT_ADDRESSED) ? h_addr : (buffered ? rd_ptr_q : 2'b00);
    assign wr_idx = (kind == PORT_ADDRESSED) ? h_addr : (buffered ? wr_ptr_q : 2'b00);

    // Interrupt event selection
    logic fourth_hit, port_evt;
    assign fourth_hit = (buffered && ((rd_end && rd_ptr_q == 2'b11) || (wr_end && wr_ptr_q == 2'b11)))
        || ((kind == PORT_ADDRESSED) && (rd_end || wr_end) && (h_addr == 2'b11));
    assign port_evt = ((irq_mode == IRQ_EACH) && (rd_end || wr_end || xf.done))
        || ((irq_mode == IRQ_FOURTH) && fourth_hit);
    assign status_d = (status_q & ~((do_wr && sel_clr) ? avs_writedata[1:0] : 2'b00))
        | {refused, port_evt};

    // Read multiplexer
    logic [15:0] cfg_view;
    assign cfg_view = {xf.busy && is_master, cfg_q[14:0]};
    assign rd_mux = sel_cfg ? {16'h0000, cfg_view}
        : sel_addr ? {21'h000000, addr_q}
        : sel_data ? {16'h0000, mdata_q}
        : sel_stat ? {30'h00000000, status_q}
        : sel_ena ? {30'h00000000, enable_q}
        : sel_out ? {out_buf_q[3], out_buf_q[2], out_buf_q[1], out_buf_q[0]}
        : sel_in ? {in_buf_q[3], in_buf_q[2], in_buf_q[1], in_buf_q[0]}
        : 32'h00000000;

    xfer_engine u_engine (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .xf(xf)
    );

    // Bus handshake and read answer
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            waitreq_q <= 1'b1;
            avs_readdata <= 32'h00000000;
        end
        else
        begin
            waitreq_q <= waitreq_d;
            if (!waitreq_d)
            begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // Configuration and interrupt registers
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            cfg_q <= MODE_CFG_RESET;
            status_q <= 2'h0;
            enable_q <= IRQ_ENABLE_RESET;
            irq <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
            irq <= |(status_d & enable_q);
            if (do_wr && sel_cfg)
            begin
                // Busy bit is read only
                cfg_q <= {1'b0, avs_writedata[14:0]};
            end
            if (do_wr && sel_ena)
            begin
                enable_q <= avs_writedata[1:0];
            end
        end
    end

    // Address counter and master read word
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            addr_q <= ADDR_RESET;
            mdata_q <= 16'h0000;
        end
        else
        begin
            if (do_wr && sel_addr)
            begin
                addr_q <= avs_writedata[10:0];
            end
            else if (xf.byte_done)
            begin
                addr_q <= step_addr(addr_q, step_mode);
            end
            if (xf.done)
            begin
                mdata_q <= xf.rdata;
            end
        end
    end

    // Host buffers and pointers
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            rd_ptr_q <= 2'b00;
            wr_ptr_q <= 2'b00;
            host_rd_act_q <= 1'b0;
            host_wr_act_q <= 1'b0;
            for (int i = 0; i < 4; i++)
            begin
                out_buf_q[i] <= 8'h00;
                in_buf_q[i] <= 8'h00;
            end
        end
        else
        begin
            host_rd_act_q <= h_rd_act;
            host_wr_act_q <= h_wr_act;
            if (wr_end)
            begin
                in_buf_q[wr_idx] <= stable_q[7:0];
            end
            if (wr_end && buffered)
            begin
                wr_ptr_q <= wr_ptr_q + 2'b01;
            end
            if (rd_end && buffered)
            begin
                rd_ptr_q <= rd_ptr_q + 2'b01;
            end
            for (int i = 0; i < 4; i++)
            begin
                if (do_wr && sel_out && avs_byteenable[i])
                begin
                    out_buf_q[i] <= avs_writedata[8*i +: 8];
                end
            end
        end
    end

    // Three-stage pin synchroniser
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            s1_q <= 13'h0000;
            s2_q <= 13'h0000;
            s3_q <= 13'h0000;
            stable_q <= 13'h0000;
        end
        else
        begin
            s1_q <= {pin_cs_in, pin_rd_in, pin_wr_in, pin_addr_in, pin_data_in};
            s2_q <= s1_q;
            s3_q <= s2_q;
            stable_q <= stable_d;
        end
    end

    // Pin drivers, master or slave
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            pin_data_out <= 8'h00;
            pin_data_oe_n <= 1'b1;
            pin_cs_out <= 1'b0;
            pin_rd_out <= 1'b0;
            pin_wr_out <= 1'b0;
            pin_en_out <= 1'b0;
            pin_ctrl_oe_n <= 1'b1;
        end
        else if (is_master)
        begin
            pin_data_out <= xf.dout;
            pin_data_oe_n <= !(xf.busy && !xf.is_read && !u_engine.rd_q);
            pin_cs_out <= xf.busy;
            pin_ctrl_oe_n <= 1'b0;
            if (kind == PORT_MASTER_COMB)
            begin
                // Direction line plus enable strobe
                pin_rd_out <= xf.busy && u_engine.rd_q;
                pin_wr_out <= 1'b0;
                pin_en_out <= xf.strobe;
            end
            else
            begin
                // Separate read and write strobes
                pin_rd_out <= xf.strobe && u_engine.rd_q;
                pin_wr_out <= xf.strobe && !u_engine.rd_q;
                pin_en_out <= 1'b0;
            end
        end
        else
        begin
            // Slave: drive data only while host reads
            pin_data_out <= out_buf_q[rd_idx];
            pin_data_oe_n <= !h_rd_act;
            pin_cs_out <= 1'b0;
            pin_rd_out <= 1'b0;
            pin_wr_out <= 1'b0;
            pin_en_out <= 1'b0;
            pin_ctrl_oe_n <= 1'b1;
        end
    end

    assign avs_waitrequest = waitreq_q;
    assign port_addr_lines = addr_q;

endmodule
`default_nettype wire

// [verif/port_mode_control_checker.sv]
`default_nettype none
module port_mode_control_checker
    import port_mode_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic irq,
    input wire logic pin_cs_in,
    input wire logic [1:0] pin_addr_in,
    input wire logic pin_cs_out,
    input wire logic pin_rd_out,
    input wire logic pin_wr_out,
    input wire logic pin_ctrl_oe_n,
    input wire logic [10:0] port_addr_lines
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [15:0] cfg_q; // Mode config shadow
    logic en_q; // Port event enable shadow
    logic aw_q; // Address register written at last edge
    wire logic acc = avs_write && !avs_waitrequest; // Accepted write
    // Shadows follow accepted writes
    always_ff @(posedge core_clk)
    begin
        cfg_q <= !rst_n ? MODE_CFG_RESET : (acc && avs_address == OFF_MODE_CFG) ? avs_writedata[15:0] : cfg_q;
        en_q <= !rst_n ? 1'b0 : (acc && avs_address == OFF_IRQ_ENABLE) ? avs_writedata[EVT_PORT] : en_q;
        aw_q <= rst_n && acc && avs_address == OFF_ADDR;
    end
    AST_RST_IDLE: assert property ($rose(rst_n) |-> avs_waitrequest && !irq && pin_ctrl_oe_n && port_addr_lines == 11'h000)
        else $error("outputs not idle after reset");
    AST_STEP: assert property ($changed(port_addr_lines) && !aw_q |->
        (cfg_q[12:11] == STEP_UP && port_addr_lines == $past(port_addr_lines) + 11'h001) ||
        (cfg_q[12:11] == STEP_DOWN && port_addr_lines == $past(port_addr_lines) - 11'h001))
        else $error("address step wrong");
    AST_STROBE_EXCL: assert property (!(pin_rd_out && pin_wr_out))
        else $error("read and write strobes together");
    AST_SLAVE_PINS: assert property (!cfg_q[9] && !$past(cfg_q[9], 2) |-> pin_ctrl_oe_n && !pin_cs_out)
        else $error("master pins active in slave kind");
    AST_STALL_IDLE: assert property (cfg_q[14:13] == IRQ_STALL && (avs_read || avs_write) &&
        avs_address == OFF_DATA && !avs_waitrequest |-> !pin_cs_out)
        else $error("stalled access answered while busy");
    AST_STALL_QUIET: assert property (cfg_q[14:13] == IRQ_STALL && $past(cfg_q[14:13], 2) == IRQ_STALL &&
        $stable(en_q) |-> !$rose(irq))
        else $error("interrupt in stall mode");
    AST_ADDR3_IRQ: assert property (cfg_q[14:13] == IRQ_FOURTH && cfg_q[9:8] == PORT_ADDRESSED && en_q &&
        $fell(pin_cs_in) && pin_addr_in == 2'b11 |-> ##[1:10] irq)
        else $error("no interrupt at address three");
    AST_EACH_IRQ: assert property ($fell(pin_cs_in) && cfg_q[14:13] == IRQ_EACH && !cfg_q[9] && en_q
        |-> ##[1:10] irq)
        else $error("no interrupt after slave cycle");
endmodule
bind port_mode_control port_mode_control_checker port_mode_control_checker_i (.core_clk, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_waitrequest, .irq, .pin_cs_in, .pin_addr_in, .pin_cs_out,
    .pin_rd_out, .pin_wr_out, .pin_ctrl_oe_n, .port_addr_lines);
`default_nettype wire

// [verif/port_host_model.sv]
`default_nettype none
module port_host_model
(
    input wire logic core_clk,
    output logic pin_cs_in,
    output logic pin_rd_in,
    output logic pin_wr_in,
    output logic [1:0] pin_addr_in,
    output logic [7:0] pin_data_in,
    input wire logic [7:0] pin_data_out,
    input wire logic pin_rd_out,
    input wire logic pin_wr_out,
    input wire logic pin_ctrl_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] PERIPH_BYTE = 8'h3C; // Byte the peripheral returns
    logic hdrv_q; // Host drives data lines
    logic [7:0] hdata_q; // Host write byte
    logic [7:0] last_q; // Last level on data lines
    logic wr_d_q; // Delayed write strobe
    logic [15:0] seen_q; // Bytes seen on master writes
    // Undriven data lines show the inverse of their last level
    assign pin_data_in = hdrv_q ? hdata_q : ((pin_rd_out && !pin_ctrl_oe_n) ? PERIPH_BYTE : ~last_q);
    initial
    begin
        {pin_cs_in, pin_rd_in, pin_wr_in, hdrv_q} = 4'h0;
        pin_addr_in = 2'h0;
        hdata_q = 8'h00;
        last_q = 8'h00;
    end
    // Records a byte at each rising write strobe
    always @(posedge core_clk)
    begin
        last_q <= pin_data_in;
        wr_d_q <= pin_wr_out;
        if (pin_wr_out && !wr_d_q)
        begin
            seen_q <= {seen_q[7:0], pin_data_out};
        end
    end
    // Host access, strobes for eight cycles, address kept one more
    task automatic host(input logic rd, input logic [1:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge core_clk);
        {pin_cs_in, pin_rd_in, pin_wr_in, hdrv_q} <= {1'b1, rd, !rd, !rd};
        pin_addr_in <= a;
        hdata_q <= d;
        repeat (8) @(posedge core_clk);
        q = pin_data_out;
        {pin_cs_in, pin_rd_in, pin_wr_in} <= 3'h0;
        @(posedge core_clk);
        hdrv_q <= 1'b0;
        pin_addr_in <= ~a;
    endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
`default_nettype none
module tb_top
    import port_mode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic rst_n, avs_read, avs_write, avs_waitrequest, irq, pin_cs_in, pin_rd_in, pin_wr_in;
    logic pin_data_oe_n, pin_cs_out, pin_rd_out, pin_wr_out, pin_en_out, pin_ctrl_oe_n;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [1:0] pin_addr_in;
    logic [7:0] pin_data_in, pin_data_out, hb;
    logic [10:0] port_addr_lines;
    logic [31:0] q;
    int mismatches = 0;
    int tests_run = 0;
    always #5 core_clk = ~core_clk;
    port_mode_control port_mode_control_i (.core_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .pin_cs_in, .pin_rd_in, .pin_wr_in, .pin_addr_in,
        .pin_data_in, .pin_data_out, .pin_data_oe_n, .pin_cs_out, .pin_rd_out, .pin_wr_out, .pin_en_out,
        .pin_ctrl_oe_n, .port_addr_lines);
    port_host_model port_host_model_i (.core_clk, .pin_cs_in, .pin_rd_in, .pin_wr_in, .pin_addr_in, .pin_data_in,
        .pin_data_out, .pin_rd_out, .pin_wr_out, .pin_ctrl_oe_n);
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // One register access, held until waitrequest is seen low
    task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] wd);
        int n = 0;
        @(posedge core_clk);
        {avs_read, avs_write} <= {rd, !rd};
        avs_address <= a;
        avs_writedata <= wd;
        do
        begin
            @(posedge core_clk);
            if (++n > 300)
            begin
                mismatches++;
                close_out();
            end
        end
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        {avs_read, avs_write} <= 2'b00;
    endtask
    // Polls the busy flag until it drops
    task automatic wait_idle;
        int n = 0;
        do
        begin
            bus(1, OFF_MODE_CFG, 0);
            n++;
        end
        while (q[BUSY_BIT] !== 1'b0 && n < 60);
        chk("busy clear", 0, q[BUSY_BIT]);
    endtask
    task automatic host_chk(input logic rd, input logic [1:0] a, input logic [7:0] d, input logic [31:0] e);
        port_host_model_i.host(rd, a, d, hb);
        repeat (8) @(posedge core_clk);
        bus(1, OFF_IRQ_STATUS, 0);
        chk("status", e, q);
    endtask
    task automatic t_regs;
        bus(1, OFF_MODE_CFG, 0);
        chk("cfg reset", 0, q);
        bus(1, OFF_IRQ_ENABLE, 0);
        chk("enable reset", 0, q);
        bus(0, OFF_MODE_CFG, 32'hFFFF);
        bus(1, OFF_MODE_CFG, 0);
        chk("busy read only", 32'h7FFF, q);
        $display("t_regs done");
    endtask
    task automatic t_master;
        bus(0, OFF_IRQ_ENABLE, 0);
        bus(0, OFF_ADDR, 32'h5);
        bus(0, OFF_MODE_CFG, 32'h36C0);
        bus(0, OFF_DATA, 32'hA55A);
        bus(1, OFF_MODE_CFG, 0);
        chk("busy set", 1, q[BUSY_BIT]);
        wait_idle();
        chk("bytes out", 32'h5AA5, port_host_model_i.seen_q);
        bus(1, OFF_ADDR, 0);
        chk("addr down", 32'h3, q);
        bus(1, OFF_IRQ_STATUS, 0);
        chk("event", 32'h1, q);
        chk("irq masked", 0, irq);
        bus(0, OFF_IRQ_ENABLE, 1);
        repeat (2) @(negedge core_clk);
        chk("irq on", 1, irq);
        bus(0, OFF_IRQ_CLEAR, 1);
        repeat (2) @(negedge core_clk);
        chk("irq off", 0, irq);
        $display("t_master done");
    endtask
    task automatic t_stall;
        bus(0, OFF_ADDR, 0);
        bus(0, OFF_MODE_CFG, 32'h4BDC);
        bus(1, OFF_DATA, 0);
        bus(1, OFF_DATA, 0);
        chk("stalled read", 32'h3C, q[7:0]);
        wait_idle();
        bus(1, OFF_ADDR, 0);
        chk("addr up", 32'h2, q);
        bus(1, OFF_IRQ_STATUS, 0);
        chk("no event", 0, q);
        $display("t_stall done");
    endtask
    task automatic t_addressed;
        bus(0, OFF_MODE_CFG, 32'h2100);
        host_chk(0, 2'h2, 8'h11, 1);
        bus(0, OFF_IRQ_CLEAR, 3);
        bus(0, OFF_MODE_CFG, 32'h6100);
        host_chk(0, 2'h2, 8'h11, 0);
        host_chk(0, 2'h3, 8'h77, 1);
        bus(1, OFF_IN_BUF, 0);
        chk("in buf", 32'h7711, q[31:16]);
        $display("t_addressed done");
    endtask
    task automatic t_buffered;
        bus(0, OFF_OUT_BUF, 32'h44332211);
        bus(0, OFF_MODE_CFG, 32'h7800);
        bus(0, OFF_IRQ_CLEAR, 3);
        for (int i = 0; i < 4; i++)
        begin
            host_chk(1, 2'h0, 8'h00, (i == 3) ? 1 : 0);
            chk("host byte", 32'h11 * (i + 1), hb);
        end
        $display("t_buffered done");
    endtask
    initial
    begin
        rst_n = 1'b0;
        {avs_read, avs_write} = 2'b00;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        t_regs();
        t_master();
        t_stall();
        t_addressed();
        t_buffered();
        close_out();
    end
endmodule
`default_nettype wire
